//--- design/gha_ctrl.sv
// gantry pair homing, alignment compensation and wishbone register file
`timescale 1ns/1ps
module gha_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] home_switch_i,
  input wire logic [1:0] axis_deceleration_input_i,
  input wire logic [1:0] marker_i,
  input wire logic signed [31:0] master_pos_i,
  input wire logic signed [31:0] slave_pos_i,
  input wire logic axis_servo_on_mark_i,
  input wire logic gantry_comp_request_mark_i,
  output logic move_o,
  output logic dir_o,
  output logic feed_second_o,
  output logic [1:0] pos_load_o,
  output logic signed [31:0] pos_load_val_o,
  output logic slave_shift_o,
  output logic signed [31:0] slave_shift_val_o,
  output logic slave_ferr_clear_o,
  output logic gantry_difference_exceeded_mark_o,
  output logic signed [31:0] limit_pos_o,
  output logic signed [31:0] limit_neg_o,
  output logic irq_o
);
  import gha_pkg::*;

  // software-visible pending values and the copies in force
  logic [GHA_CTRL_W-1:0] ctrl;
  logic [31:0] ref_m_new, ref_s_new, max_gantry_difference_new, lim_p_new, lim_n_new;
  logic signed [31:0] ref_m, ref_s;
  logic [31:0] max_gantry_difference;
  logic [GHA_IRQ_W-1:0] irq_stat, irq_mask;
  gha_state_t state;
  logic first_ax;
  logic dir_flip;
  logic [1:0] marker_q, switch_q, axis_deceleration_input_q;
  logic servo_q, req_q;
  logic [1:0] homed;

  // bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i;
  wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire wr_ctrl = bus_wr & (wb_adr_i == GHA_CTRL_OFS);
  wire wr_cmd = bus_wr & (wb_adr_i == GHA_CMD_OFS);
  wire wr_ref_m = bus_wr & (wb_adr_i == GHA_REF_M_OFS);
  wire wr_ref_s = bus_wr & (wb_adr_i == GHA_REF_S_OFS);
  wire wr_maxd = bus_wr & (wb_adr_i == GHA_MAX_GANTRY_DIFFERENCE_OFS);
  wire wr_lim_p = bus_wr & (wb_adr_i == GHA_LIM_P_OFS);
  wire wr_lim_n = bus_wr & (wb_adr_i == GHA_LIM_N_OFS);
  wire wr_istat = bus_wr & (wb_adr_i == GHA_IRQ_STAT_OFS);
  wire wr_imask = bus_wr & (wb_adr_i == GHA_IRQ_MASK_OFS);
  wire cmd_start = wr_cmd & wb_sel_i[0] & wb_dat_i[GHA_K_START];
  wire cmd_apply = wr_cmd & wb_sel_i[0] & wb_dat_i[GHA_K_APPLY];

  // configuration fields
  wire auto_gantry_comp_enable = ctrl[GHA_C_AUTO];
  wire homing_direction = ctrl[GHA_C_DIR];
  wire home_switch_present = ctrl[GHA_C_SWITCH];
  wire pair_is_gantry = ctrl[GHA_C_GANTRY_M] & ctrl[GHA_C_GANTRY_S];
  wire [1:0] marker_pulse_type = ctrl[GHA_C_PTYPE +: 2];
  wire marker_feedback_type = ctrl[GHA_C_CODED];

  // marker edge: bit0 picks trailing, bit1 picks negative polarity
  wire [1:0] mk_now = marker_i ^ {2{marker_pulse_type[1]}};
  wire [1:0] mk_old = marker_q ^ {2{marker_pulse_type[1]}};
  wire [1:0] mk_edge = marker_pulse_type[0] ? (mk_old & ~mk_now) : (~mk_old & mk_now);
  wire [1:0] sw_rise = home_switch_i & ~switch_q;
  wire [1:0] dec_rise = axis_deceleration_input_i & ~axis_deceleration_input_q;

  // mark edges against the previous cycle's sample
  wire servo_rise = axis_servo_on_mark_i & ~servo_q;
  wire req_rise = gantry_comp_request_mark_i & ~req_q;
  wire mark_comp = pair_is_gantry & ((req_rise & axis_servo_on_mark_i)
    | (servo_rise & gantry_comp_request_mark_i));
  wire ferr_fix = ~pair_is_gantry & servo_rise;

  // homing flow
  wire cur_ax = (state == GHA_SEARCH2 || state == GHA_APPROACH2) ? ~first_ax : first_ax;
  wire search_st = (state == GHA_SEARCH1) | (state == GHA_SEARCH2);
  wire found = search_st & mk_edge[cur_ax];
  // distance-coded search turns round on switch or deceleration input
  wire reverse = search_st & marker_feedback_type & (sw_rise[cur_ax] | dec_rise[cur_ax]);
  wire both_homed = (state == GHA_SEARCH2) & found;
  // the loads reach the axis positions two cycles after the last marker
  logic [1:0] auto_dly;
  wire auto_comp = auto_dly[1];

  // master minus slave after the loads; difference check guards every compensation
  wire signed [31:0] diff = master_pos_i - slave_pos_i;
  wire [31:0] diff_abs = diff[31] ? 32'(-diff) : 32'(diff);
  wire comp_try = auto_comp | mark_comp;
  wire too_far = diff_abs > max_gantry_difference;
  wire load_val_sel = cur_ax;
  wire signed [31:0] load_val = load_val_sel ? ref_s : ref_m;

  gha_state_t next_state;
  logic next_first;
  always_comb begin
    next_state = state;
    next_first = first_ax;
    unique case (state)
      GHA_IDLE: begin
        if (cmd_start) begin
          if (home_switch_present && !marker_feedback_type && (home_switch_i != 2'b00)) begin
            next_state = GHA_BACKOFF;
            next_first = ~home_switch_i[0];
          end else if (home_switch_present && !marker_feedback_type) begin
            next_state = GHA_APPROACH1;
          end else begin
            next_state = GHA_SEARCH1;
            next_first = 1'b0;
          end
        end
      end
      GHA_BACKOFF: begin
        if (home_switch_i == 2'b00) begin
          next_state = GHA_SEARCH1;
        end
      end
      GHA_APPROACH1: begin
        if (home_switch_i != 2'b00) begin
          next_state = GHA_BACKOFF;
          next_first = ~home_switch_i[0];
        end
      end
      GHA_SEARCH1: begin
        if (found) begin
          next_state = (home_switch_present && !marker_feedback_type) ? GHA_APPROACH2 : GHA_SEARCH2;
        end
      end
      GHA_APPROACH2: begin
        if (home_switch_i[~first_ax]) begin
          next_state = GHA_SEARCH2;
        end
      end
      GHA_SEARCH2: begin
        if (found) begin
          next_state = GHA_DONE;
        end
      end
      GHA_DONE: begin
        next_state = GHA_IDLE;
      end
      default: begin
        next_state = GHA_IDLE;
      end
    endcase
  end

  // direction: backing off is against the configured direction
  wire next_dir = (next_state == GHA_BACKOFF) ? ~homing_direction : (homing_direction ^ dir_flip);
  wire next_move = (next_state != GHA_IDLE) && (next_state != GHA_DONE);
  // approach at the first rate, everything else at the second
  wire next_feed2 = (next_state != GHA_APPROACH1) && (next_state != GHA_APPROACH2);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= GHA_IDLE;
      first_ax <= 1'b0;
      dir_flip <= 1'b0;
      move_o <= 1'b0;
      dir_o <= 1'b0;
      feed_second_o <= 1'b0;
      homed <= 2'b00;
    end else begin
      state <= next_state;
      first_ax <= next_first;
      move_o <= next_move;
      dir_o <= next_dir;
      feed_second_o <= next_feed2;
      if (cmd_start && state == GHA_IDLE) begin
        dir_flip <= 1'b0;
        homed <= 2'b00;
      end else if (reverse) begin
        dir_flip <= ~dir_flip;
      end
      if (found) begin
        homed[cur_ax] <= 1'b1;
      end
    end
  end

  // input and mark samples for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      marker_q <= 2'b00;
      switch_q <= 2'b00;
      axis_deceleration_input_q <= 2'b00;
      servo_q <= 1'b0;
      req_q <= 1'b0;
    end else begin
      marker_q <= marker_i;
      switch_q <= home_switch_i;
      axis_deceleration_input_q <= axis_deceleration_input_i;
      servo_q <= axis_servo_on_mark_i;
      req_q <= gantry_comp_request_mark_i;
    end
  end

  // position load, slave shift and following-error strobes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_load_o <= 2'b00;
      pos_load_val_o <= 32'sh0;
      slave_shift_o <= 1'b0;
      slave_shift_val_o <= 32'sh0;
      slave_ferr_clear_o <= 1'b0;
      gantry_difference_exceeded_mark_o <= 1'b0;
      auto_dly <= 2'b00;
    end else begin
      pos_load_o <= found ? (cur_ax ? 2'b10 : 2'b01) : 2'b00;
      if (found) begin
        pos_load_val_o <= load_val;
      end
      slave_shift_o <= comp_try & ~too_far;
      slave_ferr_clear_o <= ferr_fix;
      auto_dly <= {auto_dly[0], both_homed & auto_gantry_comp_enable};
      if (comp_try && !too_far) begin
        slave_shift_val_o <= diff;
      end
      if (comp_try) begin
        gantry_difference_exceeded_mark_o <= too_far;
      end
    end
  end

  // registers; the limits and references in force change only on reset or apply
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= GHA_CTRL_RST;
      ref_m_new <= GHA_REF_RST;
      ref_s_new <= GHA_REF_RST;
      max_gantry_difference_new <= GHA_MAX_GANTRY_DIFFERENCE_RST;
      lim_p_new <= GHA_LIM_P_RST;
      lim_n_new <= GHA_LIM_N_RST;
      ref_m <= GHA_REF_RST;
      ref_s <= GHA_REF_RST;
      max_gantry_difference <= GHA_MAX_GANTRY_DIFFERENCE_RST;
      limit_pos_o <= GHA_LIM_P_RST;
      limit_neg_o <= GHA_LIM_N_RST;
      irq_mask <= '0;
    end else begin
      if (wr_ctrl) ctrl <= (ctrl & ~bmask[GHA_CTRL_W-1:0]) | (wb_dat_i[GHA_CTRL_W-1:0] & bmask[GHA_CTRL_W-1:0]);
      if (wr_ref_m) ref_m_new <= (ref_m_new & ~bmask) | (wb_dat_i & bmask);
      if (wr_ref_s) ref_s_new <= (ref_s_new & ~bmask) | (wb_dat_i & bmask);
      if (wr_maxd) max_gantry_difference_new <= (max_gantry_difference_new & ~bmask) | (wb_dat_i & bmask);
      if (wr_lim_p) lim_p_new <= (lim_p_new & ~bmask) | (wb_dat_i & bmask);
      if (wr_lim_n) lim_n_new <= (lim_n_new & ~bmask) | (wb_dat_i & bmask);
      if (wr_imask) irq_mask <= wb_dat_i[GHA_IRQ_W-1:0];
      if (cmd_apply) begin
        ref_m <= ref_m_new;
        ref_s <= ref_s_new;
        max_gantry_difference <= max_gantry_difference_new;
        limit_pos_o <= lim_p_new;
        limit_neg_o <= lim_n_new;
      end
    end
  end

  // sticky events, write one to clear; a same-cycle event wins
  wire [GHA_IRQ_W-1:0] irq_set = {ferr_fix, comp_try & too_far, comp_try & ~too_far, both_homed};
  wire [GHA_IRQ_W-1:0] irq_clr = wr_istat ? wb_dat_i[GHA_IRQ_W-1:0] : '0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      irq_o <= |(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
    end
  end

  // read mux; unmapped and write-only offsets read zero
  wire [31:0] status_word = {24'h0, gantry_difference_exceeded_mark_o, first_ax, homed, state, move_o};
  wire [31:0] rd_mux =
    (wb_adr_i == GHA_CTRL_OFS) ? {24'h0, ctrl} :
    (wb_adr_i == GHA_REF_M_OFS) ? ref_m_new :
    (wb_adr_i == GHA_REF_S_OFS) ? ref_s_new :
    (wb_adr_i == GHA_MAX_GANTRY_DIFFERENCE_OFS) ? max_gantry_difference_new :
    (wb_adr_i == GHA_LIM_P_OFS) ? lim_p_new :
    (wb_adr_i == GHA_LIM_N_OFS) ? lim_n_new :
    (wb_adr_i == GHA_STATUS_OFS) ? status_word :
    (wb_adr_i == GHA_IRQ_STAT_OFS) ? {28'h0, irq_stat} :
    (wb_adr_i == GHA_IRQ_MASK_OFS) ? {28'h0, irq_mask} :
    (wb_adr_i == GHA_SHIFT_OFS) ? slave_shift_val_o : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) wb_dat_o <= rd_mux;
    end
  end
endmodule

//--- include/gha_pkg.sv
// package of constants for the gantry homing and alignment controller
package gha_pkg;
  localparam logic [7:0] GHA_CTRL_OFS = 8'h00;
  localparam logic [7:0] GHA_CMD_OFS = 8'h04;
  localparam logic [7:0] GHA_REF_M_OFS = 8'h08;
  localparam logic [7:0] GHA_REF_S_OFS = 8'h0c;
  localparam logic [7:0] GHA_MAX_GANTRY_DIFFERENCE_OFS = 8'h10;
  localparam logic [7:0] GHA_LIM_P_OFS = 8'h14;
  localparam logic [7:0] GHA_LIM_N_OFS = 8'h18;
  localparam logic [7:0] GHA_STATUS_OFS = 8'h1c;
  localparam logic [7:0] GHA_IRQ_STAT_OFS = 8'h20;
  localparam logic [7:0] GHA_IRQ_MASK_OFS = 8'h24;
  localparam logic [7:0] GHA_SHIFT_OFS = 8'h28;
  // ctrl fields
  localparam int GHA_C_AUTO = 0;
  localparam int GHA_C_DIR = 1;
  localparam int GHA_C_SWITCH = 2;
  localparam int GHA_C_GANTRY_M = 3;
  localparam int GHA_C_GANTRY_S = 4;
  localparam int GHA_C_PTYPE = 5;
  localparam int GHA_C_CODED = 7;
  localparam int GHA_CTRL_W = 8;
  localparam logic [GHA_CTRL_W-1:0] GHA_CTRL_RST = 8'h18;
  // cmd fields, write-only pulses
  localparam int GHA_K_START = 0;
  localparam int GHA_K_APPLY = 1;
  // irq fields
  localparam int GHA_I_HOMED = 0;
  localparam int GHA_I_COMP = 1;
  localparam int GHA_I_EXCEED = 2;
  localparam int GHA_I_FERR = 3;
  localparam int GHA_IRQ_W = 4;
  localparam logic [31:0] GHA_REF_RST = 32'h0000_0000;
  localparam logic [31:0] GHA_MAX_GANTRY_DIFFERENCE_RST = 32'h0000_1000;
  localparam logic [31:0] GHA_LIM_P_RST = 32'h7fff_ffff;
  localparam logic [31:0] GHA_LIM_N_RST = 32'h8000_0000;
  typedef enum logic [2:0] {
    GHA_IDLE = 3'b000,
    GHA_BACKOFF = 3'b001,
    GHA_APPROACH1 = 3'b010,
    GHA_SEARCH1 = 3'b011,
    GHA_APPROACH2 = 3'b100,
    GHA_SEARCH2 = 3'b101,
    GHA_DONE = 3'b110
  } gha_state_t;
endpackage

//--- test/gantry_home_alignment_ctrl_tb_top.sv
// testbench for the gantry homing and alignment controller
`timescale 1ns/1ps
module gantry_home_alignment_ctrl_tb_top;
  import gha_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [1:0] home_switch_i = 2'h0, axis_deceleration_input_i = 2'h0, marker_i = 2'h0, pos_load_o;
  logic axis_servo_on_mark_i = 1'b0, gantry_comp_request_mark_i = 1'b0, set_i = 1'b1;
  logic signed [31:0] set_m = 32'sh0, set_s = 32'sh0, master_pos_i, slave_pos_i;
  logic signed [31:0] pos_load_val_o, slave_shift_val_o, limit_pos_o, limit_neg_o;
  logic wb_ack_o, move_o, dir_o, feed_second_o, slave_shift_o, slave_ferr_clear_o;
  logic gantry_difference_exceeded_mark_o, irq_o;
  int n_fail = 0, n_compared = 0, n_shift = 0, n_ferr = 0;
  always #2.5 clk_i = ~clk_i;
  gha_ctrl i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .home_switch_i, .axis_deceleration_input_i, .marker_i, .master_pos_i, .slave_pos_i,
    .axis_servo_on_mark_i, .gantry_comp_request_mark_i, .move_o, .dir_o, .feed_second_o, .pos_load_o,
    .pos_load_val_o, .slave_shift_o, .slave_shift_val_o, .slave_ferr_clear_o, .gantry_difference_exceeded_mark_o,
    .limit_pos_o, .limit_neg_o, .irq_o);
  gha_axis_model i_axes (.clk_i, .set_i, .set_m_i(set_m), .set_s_i(set_s), .pos_load_i(pos_load_o),
    .pos_load_val_i(pos_load_val_o), .slave_shift_i(slave_shift_o), .slave_shift_val_i(slave_shift_val_o),
    .master_pos_o(master_pos_i), .slave_pos_o(slave_pos_i));
  // one-cycle pulses are counted here so the tests can check exact counts
  always @(posedge clk_i) begin
    n_shift <= n_shift + int'(slave_shift_o === 1'b1);
    n_ferr <= n_ferr + int'(slave_ferr_clear_o === 1'b1);
  end
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    q = wb_dat_o;
    if (t >= 50) n_fail++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(string what, logic [7:0] a, logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(what, q, exp);
  endtask
  task automatic marks(logic s, logic r);
    @(posedge clk_i);
    axis_servo_on_mark_i <= s;
    gantry_comp_request_mark_i <= r;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic setp(logic signed [31:0] m, logic signed [31:0] s);
    @(posedge clk_i);
    set_i <= 1'b1;
    set_m <= m;
    set_s <= s;
    @(posedge clk_i);
    set_i <= 1'b0;
  endtask
  task automatic end_sim();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("ctrl", GHA_CTRL_OFS, 32'h18);
    rd("max_gantry_difference", GHA_MAX_GANTRY_DIFFERENCE_OFS, GHA_MAX_GANTRY_DIFFERENCE_RST);
    rd("unmapped", 8'h30, 32'h0);
    wb(1'b1, GHA_LIM_P_OFS, 32'h1234);
    chk("limit before apply", limit_pos_o, 32'h7fffffff);
    wb(1'b1, GHA_CMD_OFS, 32'h2);
    repeat (2) @(posedge clk_i);
    chk("limit after apply", limit_pos_o, 32'h1234);
    $display("test registers done");
    setp(100, 40);
    marks(1'b1, 1'b0);
    chk("ferr count", n_ferr, 0);
    marks(1'b1, 1'b1);
    chk("slave after request edge", slave_pos_i, 100);
    marks(1'b0, 1'b1);
    setp(100, 40);
    marks(1'b1, 1'b1);
    chk("slave after servo edge", slave_pos_i, 100);
    chk("shift count", n_shift, 2);
    chk("exceeded low", gantry_difference_exceeded_mark_o, 0);
    marks(1'b0, 1'b0);
    wb(1'b1, GHA_MAX_GANTRY_DIFFERENCE_OFS, 32'd10);
    wb(1'b1, GHA_CMD_OFS, 32'h2);
    setp(100, 40);
    marks(1'b1, 1'b0);
    marks(1'b1, 1'b1);
    chk("exceeded high", gantry_difference_exceeded_mark_o, 1);
    chk("slave kept", slave_pos_i, 40);
    marks(1'b0, 1'b0);
    wb(1'b1, GHA_CTRL_OFS, 32'h0);
    marks(1'b0, 1'b1);
    marks(1'b1, 1'b1);
    chk("ferr non gantry", n_ferr, 1);
    chk("no shift non gantry", n_shift, 2);
    marks(1'b0, 1'b0);
    $display("test compensation done");
    wb(1'b1, GHA_CTRL_OFS, 32'h1b);
    wb(1'b1, GHA_MAX_GANTRY_DIFFERENCE_OFS, 32'h1000);
    wb(1'b1, GHA_REF_M_OFS, 32'd500);
    wb(1'b1, GHA_REF_S_OFS, 32'd480);
    wb(1'b1, GHA_CMD_OFS, 32'h2);
    wb(1'b1, GHA_IRQ_MASK_OFS, 32'h1);
    wb(1'b1, GHA_CMD_OFS, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("moving", move_o, 1);
    chk("second feed", feed_second_o, 1);
    chk("dir", dir_o, 1);
    for (int i = 0; i < 2; i++) begin
      marker_i <= 2'b01 << i;
      repeat (3) @(posedge clk_i);
      marker_i <= 2'b00;
      repeat (5) @(posedge clk_i);
    end
    chk("master ref", master_pos_i, 500);
    chk("slave aligned", slave_pos_i, 500);
    chk("stopped", move_o, 0);
    chk("shift count homing", n_shift, 3);
    chk("irq set", irq_o, 1);
    rd("last shift", GHA_SHIFT_OFS, 32'd20);
    rd("status homed", GHA_STATUS_OFS, 32'h30);
    wb(1'b1, GHA_IRQ_STAT_OFS, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", irq_o, 0);
    $display("test homing done");
    wb(1'b1, GHA_CTRL_OFS, 32'h1e);
    home_switch_i <= 2'b10;
    wb(1'b1, GHA_CMD_OFS, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("backoff dir", dir_o, 0);
    rd("first axis", GHA_STATUS_OFS, 32'h43);
    rst_i <= 1'b1;
    home_switch_i <= 2'b00;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("limit default", limit_pos_o, 32'h7fffffff);
    chk("limit neg default", limit_neg_o, GHA_LIM_N_RST);
    wb(1'b1, GHA_CTRL_OFS, 32'h9a);
    wb(1'b1, GHA_CMD_OFS, 32'h1);
    repeat (2) @(posedge clk_i);
    axis_deceleration_input_i <= 2'b01;
    repeat (3) @(posedge clk_i);
    chk("reversed", dir_o, 0);
    wb(1'b1, GHA_CTRL_OFS, 32'hba);
    marker_i <= 2'b01;
    rd("leading ignored", GHA_STATUS_OFS, 32'h07);
    marker_i <= 2'b00;
    repeat (3) @(posedge clk_i);
    rd("trailing found", GHA_STATUS_OFS, 32'h1b);
    home_switch_i <= 2'b10;
    repeat (3) @(posedge clk_i);
    chk("switch reversed", dir_o, 1);
    $display("test backoff and reverse done");
    end_sim();
  end
endmodule

//--- test/gha_axis_model.sv
// far side model: master and slave encoder positions
`timescale 1ns/1ps
module gha_axis_model (
  input wire logic clk_i,
  input wire logic set_i,
  input wire logic signed [31:0] set_m_i,
  input wire logic signed [31:0] set_s_i,
  input wire logic [1:0] pos_load_i,
  input wire logic signed [31:0] pos_load_val_i,
  input wire logic slave_shift_i,
  input wire logic signed [31:0] slave_shift_val_i,
  output logic signed [31:0] master_pos_o,
  output logic signed [31:0] slave_pos_o
);
  // axes kept still so a difference set by the bench stays put
  always @(posedge clk_i) begin
    if (set_i) begin
      master_pos_o <= set_m_i;
      slave_pos_o <= set_s_i;
    end else begin
      if (pos_load_i[0]) master_pos_o <= pos_load_val_i;
      if (pos_load_i[1]) slave_pos_o <= pos_load_val_i;
      if (slave_shift_i) slave_pos_o <= slave_pos_o + slave_shift_val_i;
    end
  end
endmodule

//--- test/gha_ctrl_props.sv
// port-level assertions for the gantry homing controller
`timescale 1ns/1ps
module gha_ctrl_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic signed [31:0] master_pos_i,
  input wire logic signed [31:0] slave_pos_i,
  input wire logic axis_servo_on_mark_i,
  input wire logic slave_shift_o,
  input wire logic signed [31:0] slave_shift_val_o,
  input wire logic slave_ferr_clear_o,
  input wire logic gantry_difference_exceeded_mark_o,
  input wire logic signed [31:0] limit_pos_o
);
  import gha_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire apply_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_dat_i[GHA_K_APPLY] & (wb_adr_i == GHA_CMD_OFS);
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ferr_has_cause: assert property (slave_ferr_clear_o |-> $past(axis_servo_on_mark_i) && !$past(axis_servo_on_mark_i, 2))
    else $error("following error clear without servo edge");
  a_shift_value_ok: assert property (slave_shift_o |-> slave_shift_val_o == $past(master_pos_i) - $past(slave_pos_i))
    else $error("slave shift value wrong");
  a_shift_one_pulse: assert property (slave_shift_o |=> !slave_shift_o)
    else $error("shift pulse repeated");
  a_ferr_one_pulse: assert property (slave_ferr_clear_o |=> !slave_ferr_clear_o)
    else $error("clear pulse repeated");
  a_exceed_no_shift: assert property (slave_shift_o |-> !gantry_difference_exceeded_mark_o)
    else $error("shift applied while difference exceeded");
  a_limit_on_apply: assert property (!$stable(limit_pos_o) |-> $past(apply_wr) || $past(apply_wr, 2) || $past(rst_i))
    else $error("limit changed without apply");
  c_shift: cover property (slave_shift_o);
  c_ferr: cover property (slave_ferr_clear_o);
  c_exceed: cover property ($rose(gantry_difference_exceeded_mark_o));
endmodule
bind gha_ctrl gha_ctrl_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
  .wb_ack_o, .master_pos_i, .slave_pos_i, .axis_servo_on_mark_i, .slave_shift_o, .slave_shift_val_o,
  .slave_ferr_clear_o, .gantry_difference_exceeded_mark_o, .limit_pos_o);
